/* verilog/bnahp_top.sv */
// host i/o port logic of the buffered network adapter
// Summary of operation
// - reads: 97 status, 96 ram byte, 94 ram byte then counter advance
// - writes: 96 command address, 95 counter low, 94 ram, 97 control
// - every host ram access uses the current address counter value
// - counter advances by one only on the post-increment port
// - port 97: ready bit7, bit6 unused, rom bit5, int bit4, nibble 3..0
// - ready reads high only while a command address byte can be taken
// - bit 7 written to port 97 is ignored
// - writing bit 5 of port 97 high enables the boot rom
// - auto-boot strap enables the boot rom three clocks after reset release without software
// - enabled boot rom answers 0000h..3FFFh and disables host internal rom
// - host sets bit 4 to enable; interrupts reach host only while set
// - reading port 97 shows interrupt state in bit 4 for polling
// - no dma overrun detection; the buffer ram makes it unnecessary
`timescale 1ns/100ps
`default_nettype none
`include "bnahp_map.svh"

module bnahp_top (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // host i/o port
  input  wire logic [7:0]  io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  output var  logic [7:0]  io_rdata,
  output var  logic        io_rvalid,
  // host memory window for the boot rom
  input  wire logic [15:0] host_mem_addr,
  output var  logic        boot_rom_cs,
  output var  logic [10:0] boot_rom_addr,
  output var  logic        internal_rom_off,
  input  wire logic        auto_boot_strap,
  // interrupt
  input  wire logic        core_irq_req,
  output var  logic        host_irq,
  // command vector address towards the adapter core
  output var  logic [23:0] cmd_vec,
  output var  logic        cmd_vec_valid,
  input  wire logic        cmd_vec_take,
  // adapter core port of the buffer ram
  input  wire logic [11:0] core_ram_addr,
  input  wire logic        core_ram_we,
  input  wire logic [7:0]  core_ram_wdata,
  output var  logic [7:0]  core_ram_rdata
);

  // ========================================================================
  // port decode, shared by the read and write paths
  function automatic bnahp_pkg::bnahp_port_type port_decode(
    input logic [7:0] a
  );
    bnahp_pkg::bnahp_port_type p;
    case (a)
      `BNAHP_PORT_AUTOINC:  p = bnahp_pkg::PORT_AUTOINC;
      `BNAHP_PORT_CTR_LOW:  p = bnahp_pkg::PORT_CTR_LOW;
      `BNAHP_PORT_DATA_CMD: p = bnahp_pkg::PORT_DATA_CMD;
      `BNAHP_PORT_STAT_CTL: p = bnahp_pkg::PORT_STAT_CTL;
      default:              p = bnahp_pkg::PORT_NONE;
    endcase
    return p;
  endfunction : port_decode

  bnahp_pkg::bnahp_port_type rd_port;
  bnahp_pkg::bnahp_port_type wr_port;
  logic                      rd_ok;
  logic                      wr_ok;

  // a simultaneous read and write strobe is treated as a write only
  assign wr_ok   = io_wr;
  assign rd_ok   = io_rd & ~io_wr;
  assign rd_port = port_decode(io_addr);
  assign wr_port = port_decode(io_addr);

  // ========================================================================
  // address counter and buffer ram
  bnahp_ram_if ram_port ();

  logic                      ram_rd_now;
  logic                      ctr_advance;
  bnahp_pkg::bnahp_addr_type ctr_value;

  // plain data port reads leave the counter alone
  assign ram_rd_now  = rd_ok & ((rd_port == bnahp_pkg::PORT_AUTOINC) |
                                (rd_port == bnahp_pkg::PORT_DATA_CMD));
  assign ctr_advance = (rd_ok & (rd_port == bnahp_pkg::PORT_AUTOINC)) |
                       (wr_ok & (wr_port == bnahp_pkg::PORT_AUTOINC));

  bnahp_addr_ctr u_ctr (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .load_high (wr_ok & (wr_port == bnahp_pkg::PORT_STAT_CTL)),
    .load_low  (wr_ok & (wr_port == bnahp_pkg::PORT_CTR_LOW)),
    .advance   (ctr_advance),
    .wdata     (io_wdata),
    .count     (ctr_value)
  );

  // ram samples the old count on the same edge the counter advances
  assign ram_port.addr  = ctr_value;
  assign ram_port.we    = wr_ok & (wr_port == bnahp_pkg::PORT_AUTOINC);
  assign ram_port.wdata = io_wdata;

  bnahp_buf_ram u_ram (
    .sys_clk    (sys_clk),
    .host       (ram_port.mem),
    .core_addr  (core_ram_addr),
    .core_we    (core_ram_we),
    .core_wdata (core_ram_wdata),
    .core_rdata (core_ram_rdata)
  );

  // ========================================================================
  // strap synchroniser: the strap is a pin, so two flops before any use
  logic strap_s1_r;
  logic strap_s2_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strap_s1_r <= 1'b0;
      strap_s2_r <= 1'b0;
    end else begin
      strap_s1_r <= auto_boot_strap;
      strap_s2_r <= strap_s1_r;
    end
  end

  // ========================================================================
  // control state: interrupt enable, rom enable, strap capture
  bnahp_pkg::bnahp_strap_type strap_st_r;
  bnahp_pkg::bnahp_strap_type strap_st_nxt;
  logic [1:0]                 fill_cnt_r;
  logic [1:0]                 fill_cnt_nxt;
  logic                       int_en_r;
  logic                       int_en_nxt;
  logic                       rom_en_r;
  logic                       rom_en_nxt;
  logic                       ctl_wr;

  assign ctl_wr = wr_ok & (wr_port == bnahp_pkg::PORT_STAT_CTL);

  // the strap is caught once the synchroniser holds a post-reset value;
  // a host write to port 97 in that window wins and the capture is dropped
  always_comb begin
    strap_st_nxt = strap_st_r;
    fill_cnt_nxt = fill_cnt_r;
    int_en_nxt   = int_en_r;
    rom_en_nxt   = rom_en_r;
    case (strap_st_r)
      bnahp_pkg::STRAP_FILL: begin
        fill_cnt_nxt = fill_cnt_r + 2'h1;
        if (fill_cnt_r == `BNAHP_STRAP_FILL) begin
          strap_st_nxt = bnahp_pkg::STRAP_DONE;
          rom_en_nxt   = strap_s2_r;
        end
      end
      bnahp_pkg::STRAP_DONE: begin
        fill_cnt_nxt = fill_cnt_r;
      end
      default: begin
        strap_st_nxt = bnahp_pkg::STRAP_DONE;
      end
    endcase
    if (ctl_wr) begin
      // bits 7 and 6 of the written byte go nowhere
      int_en_nxt = io_wdata[`BNAHP_BIT_INT_EN];
      rom_en_nxt = io_wdata[`BNAHP_BIT_ROM_EN];
      if (strap_st_r == bnahp_pkg::STRAP_FILL) begin
        strap_st_nxt = bnahp_pkg::STRAP_DONE;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strap_st_r <= bnahp_pkg::STRAP_FILL;
      fill_cnt_r <= 2'h0;
      int_en_r   <= `BNAHP_INT_EN_RST;
      rom_en_r   <= `BNAHP_ROM_EN_RST;
    end else begin
      strap_st_r <= strap_st_nxt;
      fill_cnt_r <= fill_cnt_nxt;
      int_en_r   <= int_en_nxt;
      rom_en_r   <= rom_en_nxt;
    end
  end

  // ========================================================================
  // boot rom window: a 2k part mirrored across the whole 16k range
  assign boot_rom_cs      = rom_en_r &
                            (host_mem_addr >= `BNAHP_ROM_LO) &
                            (host_mem_addr <= `BNAHP_ROM_HI);
  assign boot_rom_addr    = host_mem_addr[`BNAHP_ROM_AW-1:0];
  assign internal_rom_off = rom_en_r;

  // ========================================================================
  // interrupt gate; pending level is held by the core, not here
  assign host_irq = int_en_r & core_irq_req;

  // ========================================================================
  // command address assembly, three bytes msb first
  logic [23:0] vec_r;
  logic [23:0] vec_nxt;
  logic [1:0]  vec_cnt_r;
  logic [1:0]  vec_cnt_nxt;
  logic        vec_full_r;
  logic        vec_full_nxt;
  logic        car_ready;
  logic        car_wr;

  // ready drops while a full vector waits for the core to take it
  assign car_ready = ~vec_full_r;
  assign car_wr    = wr_ok & (wr_port == bnahp_pkg::PORT_DATA_CMD);

  // a byte written while not ready is dropped; polling keeps this away
  always_comb begin
    vec_nxt      = vec_r;
    vec_cnt_nxt  = vec_cnt_r;
    vec_full_nxt = vec_full_r;
    if (vec_full_r && cmd_vec_take) begin
      vec_full_nxt = 1'b0;
    end
    if (car_wr && car_ready) begin
      vec_nxt = {vec_r[15:0], io_wdata};
      if (vec_cnt_r == `BNAHP_VEC_BYTES - 2'h1) begin
        vec_cnt_nxt  = 2'h0;
        vec_full_nxt = 1'b1;
      end else begin
        vec_cnt_nxt = vec_cnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      vec_r      <= `BNAHP_VEC_RST;
      vec_cnt_r  <= 2'h0;
      vec_full_r <= 1'b0;
    end else begin
      vec_r      <= vec_nxt;
      vec_cnt_r  <= vec_cnt_nxt;
      vec_full_r <= vec_full_nxt;
    end
  end

  assign cmd_vec       = vec_r;
  assign cmd_vec_valid = vec_full_r;

  // ========================================================================
  // read path: decode in cycle 0, ram data in cycle 1, bus data in cycle 2
  bnahp_pkg::bnahp_port_type rd_port_r;
  bnahp_pkg::bnahp_port_type rd_port_nxt;
  logic                      rd_pend_r;
  logic                      rd_pend_nxt;
  logic [7:0]                stat_r;
  logic [7:0]                stat_nxt;
  logic [7:0]                rdata_r;
  logic [7:0]                rdata_nxt;
  logic                      rvalid_r;
  logic                      rvalid_nxt;

  // status is sampled with the request so it matches the ram timing
  always_comb begin
    rd_pend_nxt = rd_ok;
    rd_port_nxt = rd_ok ? rd_port : bnahp_pkg::PORT_NONE;
    stat_nxt    = 8'h00;                                      // bit 6 zero
    stat_nxt[`BNAHP_BIT_READY]  = car_ready;
    stat_nxt[`BNAHP_BIT_ROM_EN] = rom_en_r;
    stat_nxt[`BNAHP_BIT_INT_EN] = core_irq_req;
    stat_nxt[`BNAHP_NIB_MSB:`BNAHP_NIB_LSB] = ctr_value[11:8];
    rvalid_nxt = rd_pend_r;
    rdata_nxt  = rdata_r;
    if (rd_pend_r) begin
      case (rd_port_r)
        bnahp_pkg::PORT_STAT_CTL: rdata_nxt = stat_r;
        bnahp_pkg::PORT_DATA_CMD: rdata_nxt = ram_port.rdata;
        bnahp_pkg::PORT_AUTOINC:  rdata_nxt = ram_port.rdata;
        default:                  rdata_nxt = `BNAHP_UNMAPPED_DATA;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_pend_r <= 1'b0;
      rd_port_r <= bnahp_pkg::PORT_NONE;
      stat_r    <= 8'h00;
      rdata_r   <= `BNAHP_RDATA_RST;
      rvalid_r  <= 1'b0;
    end else begin
      rd_pend_r <= rd_pend_nxt;
      rd_port_r <= rd_port_nxt;
      stat_r    <= stat_nxt;
      rdata_r   <= rdata_nxt;
      rvalid_r  <= rvalid_nxt;
    end
  end

  assign io_rdata  = rdata_r;
  assign io_rvalid = rvalid_r;

  // ========================================================================
  // transfers run through the buffer ram, so there is deliberately no
  // overrun detector anywhere in this block

endmodule : bnahp_top

`default_nettype wire

/* verilog/bnahp_map.svh */
// register offsets, field positions, reset values and sizes of the host port
`ifndef BNAHP_MAP_SVH
`define BNAHP_MAP_SVH

// ==========================================================================
// host i/o port offsets
`define BNAHP_PORT_AUTOINC   8'h94
`define BNAHP_PORT_CTR_LOW   8'h95
`define BNAHP_PORT_DATA_CMD  8'h96
`define BNAHP_PORT_STAT_CTL  8'h97

// ==========================================================================
// status/control field positions
`define BNAHP_BIT_READY      7
`define BNAHP_BIT_ROM_EN     5
`define BNAHP_BIT_INT_EN     4
`define BNAHP_NIB_MSB        3
`define BNAHP_NIB_LSB        0

// ==========================================================================
// reset values and the data returned for unmapped reads
`define BNAHP_CTR_RST        12'h000
`define BNAHP_INT_EN_RST     1'b0
`define BNAHP_ROM_EN_RST     1'b0
`define BNAHP_VEC_RST        24'h000000
`define BNAHP_RDATA_RST      8'h00
`define BNAHP_UNMAPPED_DATA  8'hFF

// ==========================================================================
// sizes and ranges
`define BNAHP_CTR_W          12
`define BNAHP_RAM_DEPTH      4096
`define BNAHP_ROM_AW         11
`define BNAHP_ROM_LO         16'h0000
`define BNAHP_ROM_HI         16'h3FFF
`define BNAHP_VEC_BYTES      2'h3
`define BNAHP_STRAP_FILL     2'h2

`endif

/* verilog/bnahp_pkg.sv */
// shared types of the buffered adapter host port
`default_nettype none

package bnahp_pkg;

  // ========================================================================
  // decoded host i/o port
  typedef enum logic [2:0] {
    PORT_NONE,
    PORT_AUTOINC,
    PORT_CTR_LOW,
    PORT_DATA_CMD,
    PORT_STAT_CTL
  } bnahp_port_type;

  // ========================================================================
  // strap capture sequence after reset release
  typedef enum logic [1:0] {
    STRAP_FILL,
    STRAP_DONE
  } bnahp_strap_type;

  typedef logic [11:0] bnahp_addr_type;
  typedef logic [7:0]  bnahp_byte_type;

endpackage : bnahp_pkg

`default_nettype wire

/* verilog/bnahp_ram_if.sv */
// host-side port of the buffer ram, between port logic and memory
`timescale 1ns/100ps
`default_nettype none

interface bnahp_ram_if;
  bnahp_pkg::bnahp_addr_type addr;
  logic                      we;
  bnahp_pkg::bnahp_byte_type wdata;
  bnahp_pkg::bnahp_byte_type rdata;

  modport ctl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface : bnahp_ram_if

`default_nettype wire

/* verilog/bnahp_buf_ram.sv */
// dual-port buffer ram, host port and adapter core port, registered reads
`timescale 1ns/100ps
`default_nettype none
`include "bnahp_map.svh"

module bnahp_buf_ram (
  input  wire logic                      sys_clk,
  bnahp_ram_if.mem                       host,
  input  wire bnahp_pkg::bnahp_addr_type core_addr,
  input  wire logic                      core_we,
  input  wire bnahp_pkg::bnahp_byte_type core_wdata,
  output var  bnahp_pkg::bnahp_byte_type core_rdata
);

  bnahp_pkg::bnahp_byte_type mem_r [0:`BNAHP_RAM_DEPTH-1];
  bnahp_pkg::bnahp_byte_type host_rdata_r;
  bnahp_pkg::bnahp_byte_type core_rdata_r;

  // ========================================================================
  // one process for both writes: a clash on one address lets the core win
  always_ff @(posedge sys_clk) begin
    if (host.we) begin
      mem_r[host.addr] <= host.wdata;
    end
    if (core_we) begin
      mem_r[core_addr] <= core_wdata;
    end
    host_rdata_r <= mem_r[host.addr];   // read before write
    core_rdata_r <= mem_r[core_addr];
  end

  assign host.rdata = host_rdata_r;
  assign core_rdata = core_rdata_r;

endmodule : bnahp_buf_ram

`default_nettype wire

/* verilog/bnahp_addr_ctr.sv */
// 12-bit buffer address counter, split loads and post-increment
`timescale 1ns/100ps
`default_nettype none
`include "bnahp_map.svh"

module bnahp_addr_ctr (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      load_high,
  input  wire logic                      load_low,
  input  wire logic                      advance,
  input  wire bnahp_pkg::bnahp_byte_type wdata,
  output var  bnahp_pkg::bnahp_addr_type count
);

  bnahp_pkg::bnahp_addr_type count_r;
  bnahp_pkg::bnahp_addr_type count_nxt;

  // ========================================================================
  // each load touches only its own part; loads and advance never coincide
  always_comb begin
    count_nxt = count_r;
    if (load_high) begin
      count_nxt[11:8] = wdata[`BNAHP_NIB_MSB:`BNAHP_NIB_LSB];
    end else if (load_low) begin
      count_nxt[7:0] = wdata;
    end else if (advance) begin
      count_nxt = count_r + 12'h001;  // wraps at the top
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_r <= `BNAHP_CTR_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;

endmodule : bnahp_addr_ctr

`default_nettype wire

/* tb/bnahp_top_monitor.sv */
// concurrent checks on the host port pins of the adapter
`timescale 1ns/100ps
`default_nettype none

module bnahp_top_monitor (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [7:0]  io_addr,
  input wire logic        io_rd,
  input wire logic        io_wr,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rvalid,
  input wire logic [15:0] host_mem_addr,
  input wire logic        boot_rom_cs,
  input wire logic [10:0] boot_rom_addr,
  input wire logic        internal_rom_off,
  input wire logic        core_irq_req,
  input wire logic        host_irq,
  input wire logic [23:0] cmd_vec,
  input wire logic        cmd_vec_valid,
  input wire logic        cmd_vec_take
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ========================================================================
  // host cycles; write wins when both strobes are up
  sequence s_rd;
    io_rd && !io_wr;
  endsequence
  sequence s_stat_rd;
    s_rd ##0 io_addr == 8'h97;
  endsequence
  sequence s_ctl_wr;
    io_wr && io_addr == 8'h97;
  endsequence

  // ========================================================================
  // read answers: pulse sampled high two edges after the strobe edge
  chk_rd_answer: assert property (s_rd |-> ##2 io_rvalid)
    else $error("read answer missing");
  chk_rvalid_cause: assert property (io_rvalid |->
    $past(io_rd, 2) && !$past(io_wr, 2))
    else $error("read answer without read");
  chk_status_bits: assert property (s_stat_rd |-> ##2
    io_rdata[7] == !$past(cmd_vec_valid, 2) && !io_rdata[6]
    && io_rdata[4] == $past(core_irq_req, 2))
    else $error("status fields wrong");

  // ========================================================================
  // boot rom window
  chk_rom_window: assert property (boot_rom_cs |->
    internal_rom_off && host_mem_addr <= 16'h3FFF)
    else $error("rom select outside window");
  chk_rom_select: assert property (internal_rom_off
    && host_mem_addr <= 16'h3FFF |->
    boot_rom_cs && boot_rom_addr == host_mem_addr[10:0])
    else $error("rom not selected in window");
  chk_rom_write: assert property (s_ctl_wr |=>
    internal_rom_off == $past(io_wdata[5]))
    else $error("rom enable not loaded");

  // ========================================================================
  // interrupt gating
  chk_irq_gate: assert property (host_irq |-> core_irq_req)
    else $error("interrupt without request");
  chk_irq_disable: assert property (s_ctl_wr ##0 !io_wdata[4]
    |=> !host_irq)
    else $error("interrupt while disabled");

  // ========================================================================
  // command vector handoff
  chk_vec_hold: assert property (cmd_vec_valid && !cmd_vec_take
    |=> cmd_vec_valid && $stable(cmd_vec))
    else $error("held vector changed");
  chk_vec_take: assert property (cmd_vec_valid && cmd_vec_take
    |=> !cmd_vec_valid)
    else $error("taken vector still valid");
endmodule : bnahp_top_monitor

`default_nettype wire

/* tb/bnahp_host_model.sv */
// host processor model issuing i/o port cycles to the adapter
`timescale 1ns/100ps
`default_nettype none

module bnahp_host_model (
  input  wire logic       sys_clk,
  output var  logic [7:0] io_addr,
  output var  logic       io_rd,
  output var  logic       io_wr,
  output var  logic [7:0] io_wdata,
  input  wire logic [7:0] io_rdata,
  input  wire logic       io_rvalid
);
  // ========================================================================
  // bus cycles
  initial begin
    io_addr  = 8'h00;
    io_rd    = 1'b0;
    io_wr    = 1'b0;
    io_wdata = 8'h00;
  end

  // one strobe cycle; idle lines show inverted junk, not the last value
  task automatic cyc(input logic [7:0] a, input logic [7:0] d,
                     input logic w);
    @(posedge sys_clk);
    #1;
    io_addr  = a;
    io_wdata = d;
    io_wr    = w;
    io_rd    = !w;
    @(posedge sys_clk);
    #1;
    io_addr  = ~a;
    io_wdata = ~d;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(a, d, 1'b1);
  endtask : wr

  // the answer is settled just after the second edge past the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    cyc(a, 8'h00, 1'b0);
    @(posedge sys_clk);
    #1;
    ok = io_rvalid;
    d  = io_rdata;
  endtask : rd

  // poll ready before each byte, most significant byte first
  task automatic send_vec(input logic [23:0] v, output logic ok);
    logic [7:0] s;
    logic       r;
    ok = 1'b1;
    for (int b = 2; b >= 0; b--) begin
      s = 8'h00;
      for (int i = 0; i < 8 && !s[7]; i++) begin
        rd(8'h97, s, r);
      end
      ok = ok && s[7];
      if (s[7]) begin
        wr(8'h96, v[b*8 +: 8]);
      end
    end
  endtask : send_vec
endmodule : bnahp_host_model

`default_nettype wire

/* tb/test_buffered_net_adapter_host_port.sv */
// self-checking bench of the adapter host port
`timescale 1ns/100ps
`default_nettype none

module test_buffered_net_adapter_host_port;
  logic        sys_clk, rst, io_rd, io_wr, io_rvalid, boot_rom_cs;
  logic        internal_rom_off, auto_boot_strap, core_irq_req, host_irq;
  logic        cmd_vec_valid, cmd_vec_take, core_ram_we, ok;
  logic [7:0]  io_addr, io_wdata, io_rdata, core_ram_wdata, core_ram_rdata;
  logic [10:0] boot_rom_addr;
  logic [11:0] core_ram_addr;
  logic [15:0] host_mem_addr;
  logic [23:0] cmd_vec;
  int          n_errors, num_checks, cycles;

  bnahp_top u_bnahp_top (.sys_clk, .rst, .io_addr, .io_rd, .io_wr,
    .io_wdata, .io_rdata, .io_rvalid, .host_mem_addr, .boot_rom_cs,
    .boot_rom_addr, .internal_rom_off, .auto_boot_strap, .core_irq_req,
    .host_irq, .cmd_vec, .cmd_vec_valid, .cmd_vec_take, .core_ram_addr,
    .core_ram_we, .core_ram_wdata, .core_ram_rdata);
  bnahp_host_model u_host (.sys_clk, .io_addr, .io_rd, .io_wr, .io_wdata,
    .io_rdata, .io_rvalid);

  // ========================================================================
  // clock and hang guard
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    u_host.rd(a, d, v);
    chk({nm, " rvalid"}, 24'h1, {23'h0, v});
    chk(nm, {16'h0, e}, {16'h0, d});
  endtask : rdc

  // strap is held steady across the whole reset
  task automatic do_reset;
    rst = 1'b1;
    repeat (12) @(posedge sys_clk);
    #1;
    rst = 1'b0;
  endtask : do_reset

  // ========================================================================
  // scenarios
  task automatic t_reset;
    rdc("status", 8'h97, 8'h80);
    chk("rom off", 24'h0, {23'h0, internal_rom_off});
    rdc("unmapped", 8'h90, 8'hFF);
    rdc("low rd", 8'h95, 8'hFF);
    $display("test reset done");
  endtask : t_reset

  task automatic t_ram;
    u_host.wr(8'h97, 8'h03);
    u_host.wr(8'h95, 8'h10);
    u_host.wr(8'h94, 8'hA5);
    u_host.wr(8'h94, 8'h5A);
    rdc("nibble", 8'h97, 8'h83);
    u_host.wr(8'h95, 8'h10);
    rdc("plain 1", 8'h96, 8'hA5);
    rdc("plain 2", 8'h96, 8'hA5);
    rdc("inc 1", 8'h94, 8'hA5);
    rdc("inc 2", 8'h94, 8'h5A);
    @(posedge sys_clk);
    #1;
    core_ram_addr = 12'h311;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("core rd", 24'h5A, {16'h0, core_ram_rdata});
    // core writes the byte the host counter points at next
    core_ram_addr  = 12'h312;
    core_ram_wdata = 8'h6C;
    core_ram_we    = 1'b1;
    @(posedge sys_clk);
    #1;
    core_ram_we    = 1'b0;
    rdc("core wr", 8'h96, 8'h6C);
    u_host.wr(8'h97, 8'h0F);
    u_host.wr(8'h95, 8'hFF);
    u_host.wr(8'h94, 8'hC3);
    rdc("wrap", 8'h97, 8'h80);
    $display("test ram done");
  endtask : t_ram

  task automatic t_cmd;
    u_host.send_vec(24'h123456, ok);
    chk("ready seen", 24'h1, {23'h0, ok});
    chk("vector", 24'h123456, cmd_vec);
    chk("vec valid", 24'h1, {23'h0, cmd_vec_valid});
    rdc("busy", 8'h97, 8'h00);
    u_host.wr(8'h96, 8'h77);
    chk("dropped", 24'h123456, cmd_vec);
    @(posedge sys_clk);
    #1;
    cmd_vec_take = 1'b1;
    @(posedge sys_clk);
    #1;
    cmd_vec_take = 1'b0;
    @(posedge sys_clk);
    #1;
    chk("taken", 24'h0, {23'h0, cmd_vec_valid});
    rdc("ready", 8'h97, 8'h80);
    $display("test cmd done");
  endtask : t_cmd

  task automatic t_ctl;
    logic [15:0] a;
    core_irq_req = 1'b1;
    u_host.wr(8'h97, 8'hD5);
    rdc("ctl", 8'h97, 8'h95);
    chk("irq on", 24'h1, {23'h0, host_irq});
    core_irq_req = 1'b0;
    @(posedge sys_clk);
    #1;
    chk("irq idle", 24'h0, {23'h0, host_irq});
    rdc("no pend", 8'h97, 8'h85);
    core_irq_req = 1'b1;
    u_host.wr(8'h97, 8'h25);
    chk("rom on", 24'h1, {23'h0, internal_rom_off});
    chk("irq off", 24'h0, {23'h0, host_irq});
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 16'h0000 : (i == 1) ? 16'h3FFF :
          (i == 2) ? 16'h4000 : 16'h1A2B;
      host_mem_addr = a;
      @(posedge sys_clk);
      #1;
      chk("rom cs", {23'h0, a <= 16'h3FFF}, {23'h0, boot_rom_cs});
      chk("rom addr", {13'h0, a[10:0]}, {13'h0, boot_rom_addr});
    end
    u_host.wr(8'h97, 8'h05);
    chk("rom off", 24'h0, {23'h0, boot_rom_cs});
    core_irq_req = 1'b0;
    $display("test ctl done");
  endtask : t_ctl

  task automatic t_strap;
    auto_boot_strap = 1'b1;
    do_reset();
    repeat (5) @(posedge sys_clk);
    #1;
    chk("strap rom", 24'h1, {23'h0, internal_rom_off});
    rdc("strap st", 8'h97, 8'hA0);
    $display("test strap done");
  endtask : t_strap

  // ========================================================================
  // main sequence
  initial begin
    sys_clk         = 1'b0;
    rst             = 1'b1;
    auto_boot_strap = 1'b0;
    core_irq_req    = 1'b0;
    cmd_vec_take    = 1'b0;
    host_mem_addr   = 16'h0000;
    core_ram_addr   = 12'h000;
    core_ram_we     = 1'b0;
    core_ram_wdata  = 8'h00;
    n_errors        = 0;
    num_checks      = 0;
    cycles          = 0;
    do_reset();
    t_reset();
    t_ram();
    t_cmd();
    t_ctl();
    t_strap();
    summarize();
  end

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
endmodule : test_buffered_net_adapter_host_port

bind bnahp_top bnahp_top_monitor u_bnahp_top_monitor (.sys_clk, .rst,
  .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata, .io_rvalid,
  .host_mem_addr, .boot_rom_cs, .boot_rom_addr, .internal_rom_off,
  .core_irq_req, .host_irq, .cmd_vec, .cmd_vec_valid, .cmd_vec_take);

`default_nettype wire
